/* File: rtl/adcr_pkg.sv */
package adcr_pkg;

    // Byte addresses of the configuration registers.
    localparam logic [11:0] OFS_POWER = 12'h004;
    localparam logic [11:0] OFS_INPUT = 12'h008;
    localparam logic [11:0] OFS_OUTPUT = 12'h00c;
    localparam logic [11:0] OFS_WORD = 12'h010;
    localparam logic [11:0] OFS_PAT_LO = 12'h014;
    localparam logic [11:0] OFS_PAT_MID = 12'h015;
    localparam logic [11:0] OFS_PAT_HI = 12'h016;
    localparam logic [11:0] OFS_OFFSET = 12'h020;
    localparam logic [11:0] OFS_MARGIN = 12'h030;

    // Storage slots of the register array, one per register.
    localparam logic [3:0] SLOT_POWER = 4'h0;
    localparam logic [3:0] SLOT_INPUT = 4'h1;
    localparam logic [3:0] SLOT_OUTPUT = 4'h2;
    localparam logic [3:0] SLOT_WORD = 4'h3;
    localparam logic [3:0] SLOT_PAT_LO = 4'h4;
    localparam logic [3:0] SLOT_PAT_MID = 4'h5;
    localparam logic [3:0] SLOT_PAT_HI = 4'h6;
    localparam logic [3:0] SLOT_OFFSET = 4'h7;
    localparam logic [3:0] SLOT_MARGIN = 4'h8;
    localparam logic [3:0] SLOT_NONE = 4'hf;
    localparam int NUM_REGS = 9;

    // Writable bits of each register; the rest are reserved.
    localparam logic [7:0] MASK_POWER = 8'h06;
    localparam logic [7:0] MASK_INPUT = 8'h03;
    localparam logic [7:0] MASK_OUTPUT = 8'hdf;
    localparam logic [7:0] MASK_WORD = 8'h0f;
    localparam logic [7:0] MASK_BYTE = 8'hff;
    localparam logic [7:0] MASK_PAT_HI = 8'h0f;
    localparam logic [7:0] MASK_OFFSET = 8'h07;

    // Values after reset.
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_OUTPUT = 8'h00;
    localparam logic [7:0] RST_OTHER = 8'h00;

    // Field positions.
    localparam int BIT_REFBUF_OFF = 2;
    localparam int BIT_CONV_OFF = 1;
    localparam int BIT_IN_CPOL = 1;
    localparam int BIT_IN_CPHA = 0;
    localparam int BIT_OUT_RATE = 4;
    localparam int LSB_OUT_LANES = 2;
    localparam int LSB_OUT_CLK = 6;
    localparam int LSB_OUT_MODE = 0;

    // Output mode and lane count codes.
    localparam logic [1:0] MODE_SPI = 2'h0;
    localparam logic [1:0] MODE_EARLY = 2'h1;
    localparam logic [1:0] MODE_BAD = 2'h2;
    localparam logic [1:0] MODE_SYNC = 2'h3;
    localparam logic [1:0] LANES_TWO = 2'h2;
    localparam logic [1:0] LANES_FOUR = 2'h3;
    localparam logic [3:0] LANE_EN_ONE = 4'h1;
    localparam logic [3:0] LANE_EN_TWO = 4'h3;
    localparam logic [3:0] LANE_EN_FOUR = 4'hf;
    localparam logic [1:0] CLK_ECHO = 2'h0;

endpackage : adcr_pkg

/* File: rtl/adcr_regs.sv */
// What this block does
// R1: Power bit 2 set powers the reference buffer down; clear powers it up.
// R2: Power bit 1 set powers the converter core down; clear powers it up.
// R3: Converter power-down takes effect at the next chip-select rising edge only.
// R4: Converter power-up sequence starts at the chip-select rising edge ending the write.
// R5: Host waits the converter wake time before any conversion or transfer frame.
// R6: Reference buffer power-down takes effect at the next chip-select rising edge.
// R7: Buffer wake starts at chip-select rise; host waits buffer wake time.
// R8: Power register bits 7-3 and 0 read zero; host never writes bit 0.
// R9: Input frame mode bits 1-0 select clock polarity and phase.
// R10: Input register bits 7-2 read zero; host never writes them.
// R11: Output clock select bits 7-6 apply only in source-synchronous mode.
// R12: Output bit 4 picks single or double data rate; ignored outside mode 11.
// R13: Lane count bits 3-2 drive one, two or four output lanes.
// R14: Output mode 00 reuses the input polarity and phase.
// R15: Output mode 01 reuses input polarity and phase with early launch.
// R16: Host never programs output mode 10.
// R17: Output mode 11 drives lanes source-synchronously with the selected clock.
// R18: Output bit 5 reads zero; host never writes it.
// R19: Nine configuration registers sit between addresses 004h and 030h.
// R20: Power and output registers reset to 00h: standard output, all powered.
// R21: Chained devices share identical setup and use output modes 00 or 01.
// R22: Reserved bits and unmapped addresses read zero; such writes are ignored.
`timescale 1ns/1ps
module adcr_regs (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_pin_b,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [11:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic conv_power_off,
    output logic refbuf_power_off,
    output logic conv_wake_start,
    output logic refbuf_wake_start,
    output logic in_cpol,
    output logic in_cpha,
    output logic out_cpol,
    output logic out_cpha,
    output logic out_early_launch,
    output logic out_source_sync,
    output logic out_ddr,
    output logic [1:0] output_clock_select,
    output logic [3:0] output_lane_en,
    output logic output_mode_bad,
    output logic [3:0] output_word_config,
    output logic [19:0] pattern_word,
    output logic [2:0] offset_ref_select,
    output logic [7:0] reference_margin
);

    // Maps a byte address to its storage slot.
    function automatic logic [3:0] slot_of(input logic [11:0] addr);
        logic [3:0] s;
        s = adcr_pkg::SLOT_NONE;
        unique case (addr)
            adcr_pkg::OFS_POWER: s = adcr_pkg::SLOT_POWER;
            adcr_pkg::OFS_INPUT: s = adcr_pkg::SLOT_INPUT;
            adcr_pkg::OFS_OUTPUT: s = adcr_pkg::SLOT_OUTPUT;
            adcr_pkg::OFS_WORD: s = adcr_pkg::SLOT_WORD;
            adcr_pkg::OFS_PAT_LO: s = adcr_pkg::SLOT_PAT_LO;
            adcr_pkg::OFS_PAT_MID: s = adcr_pkg::SLOT_PAT_MID;
            adcr_pkg::OFS_PAT_HI: s = adcr_pkg::SLOT_PAT_HI;
            adcr_pkg::OFS_OFFSET: s = adcr_pkg::SLOT_OFFSET;
            adcr_pkg::OFS_MARGIN: s = adcr_pkg::SLOT_MARGIN;
            default: s = adcr_pkg::SLOT_NONE;
        endcase
        return s;
    endfunction : slot_of

    // Writable bits of a slot; unmapped slots have none.
    function automatic logic [7:0] mask_of(input logic [3:0] slot);
        logic [7:0] m;
        m = 8'h00;
        unique case (slot)
            adcr_pkg::SLOT_POWER: m = adcr_pkg::MASK_POWER;
            adcr_pkg::SLOT_INPUT: m = adcr_pkg::MASK_INPUT;
            adcr_pkg::SLOT_OUTPUT: m = adcr_pkg::MASK_OUTPUT;
            adcr_pkg::SLOT_WORD: m = adcr_pkg::MASK_WORD;
            adcr_pkg::SLOT_PAT_LO: m = adcr_pkg::MASK_BYTE;
            adcr_pkg::SLOT_PAT_MID: m = adcr_pkg::MASK_BYTE;
            adcr_pkg::SLOT_PAT_HI: m = adcr_pkg::MASK_PAT_HI;
            adcr_pkg::SLOT_OFFSET: m = adcr_pkg::MASK_OFFSET;
            adcr_pkg::SLOT_MARGIN: m = adcr_pkg::MASK_BYTE;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : mask_of

    logic [7:0] regs_q [adcr_pkg::NUM_REGS];
    logic [3:0] wr_slot;
    logic [3:0] rd_slot;
    logic [7:0] power_d;
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic cs_level_q;
    logic cs_rise;
    logic [1:0] mode_w;

    assign wr_slot = slot_of(reg_addr); // [R19]
    assign rd_slot = slot_of(reg_addr);

    // Chip select comes from a pin and passes three flip-flops.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_pin_b;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // A level change counts once the second and third stages agree.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cs_level_q <= 1'b1;
        end else if (cs_s2_q == cs_s3_q) begin
            cs_level_q <= cs_s3_q;
        end
    end

    assign cs_rise = !cs_level_q && cs_s2_q && cs_s3_q;

    // Register writes keep only the writable bits of mapped registers.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            regs_q[adcr_pkg::SLOT_POWER] <= adcr_pkg::RST_POWER; // [R20]
            regs_q[adcr_pkg::SLOT_OUTPUT] <= adcr_pkg::RST_OUTPUT; // [R20]
            regs_q[adcr_pkg::SLOT_INPUT] <= adcr_pkg::RST_OTHER;
            regs_q[adcr_pkg::SLOT_WORD] <= adcr_pkg::RST_OTHER;
            regs_q[adcr_pkg::SLOT_PAT_LO] <= adcr_pkg::RST_OTHER;
            regs_q[adcr_pkg::SLOT_PAT_MID] <= adcr_pkg::RST_OTHER;
            regs_q[adcr_pkg::SLOT_PAT_HI] <= adcr_pkg::RST_OTHER;
            regs_q[adcr_pkg::SLOT_OFFSET] <= adcr_pkg::RST_OTHER;
            regs_q[adcr_pkg::SLOT_MARGIN] <= adcr_pkg::RST_OTHER;
        end else if (reg_wr && wr_slot != adcr_pkg::SLOT_NONE) begin
            regs_q[wr_slot] <= reg_wdata & mask_of(wr_slot); // [R8] [R10] [R18] [R22]
        end
    end

    // Read data is registered; reserved and unmapped bits read zero.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd && rd_slot != adcr_pkg::SLOT_NONE) begin
                reg_rdata <= regs_q[rd_slot];
            end else if (reg_rd) begin
                reg_rdata <= 8'h00; // [R22]
            end
        end
    end

    // Power value seen at a chip-select rise, including a same-cycle write.
    always_comb begin
        power_d = regs_q[adcr_pkg::SLOT_POWER];
        if (reg_wr && wr_slot == adcr_pkg::SLOT_POWER) begin
            power_d = reg_wdata & adcr_pkg::MASK_POWER;
        end
    end

    // Power states change only on a chip-select rising edge.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            conv_power_off <= 1'b0;
            refbuf_power_off <= 1'b0;
        end else if (cs_rise) begin
            conv_power_off <= power_d[adcr_pkg::BIT_CONV_OFF]; // [R2] [R3] [R4]
            refbuf_power_off <= power_d[adcr_pkg::BIT_REFBUF_OFF]; // [R1] [R6] [R7]
        end
    end

    // One-cycle pulses mark the start of each wake-up sequence.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            conv_wake_start <= 1'b0;
            refbuf_wake_start <= 1'b0;
        end else begin
            conv_wake_start <= cs_rise && conv_power_off
                && !power_d[adcr_pkg::BIT_CONV_OFF]; // [R4] [R5]
            refbuf_wake_start <= cs_rise && refbuf_power_off
                && !power_d[adcr_pkg::BIT_REFBUF_OFF]; // [R7]
        end
    end

    assign mode_w = regs_q[adcr_pkg::SLOT_OUTPUT][adcr_pkg::LSB_OUT_MODE +: 2];

    // Input frame clock polarity and phase.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            in_cpol <= 1'b0;
            in_cpha <= 1'b0;
        end else begin
            in_cpol <= regs_q[adcr_pkg::SLOT_INPUT][adcr_pkg::BIT_IN_CPOL]; // [R9]
            in_cpha <= regs_q[adcr_pkg::SLOT_INPUT][adcr_pkg::BIT_IN_CPHA]; // [R9]
        end
    end

    // Output protocol decode from the output-control register.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_cpol <= 1'b0;
            out_cpha <= 1'b0;
            out_early_launch <= 1'b0;
            out_source_sync <= 1'b0;
            out_ddr <= 1'b0;
            output_clock_select <= adcr_pkg::CLK_ECHO;
            output_mode_bad <= 1'b0;
        end else begin
            // Legacy modes borrow the input frame's polarity and phase.
            out_cpol <= regs_q[adcr_pkg::SLOT_INPUT][adcr_pkg::BIT_IN_CPOL]; // [R14]
            out_cpha <= regs_q[adcr_pkg::SLOT_INPUT][adcr_pkg::BIT_IN_CPHA]; // [R14]
            out_early_launch <= mode_w == adcr_pkg::MODE_EARLY; // [R15]
            out_source_sync <= mode_w == adcr_pkg::MODE_SYNC; // [R17]
            out_ddr <= mode_w == adcr_pkg::MODE_SYNC
                && regs_q[adcr_pkg::SLOT_OUTPUT][adcr_pkg::BIT_OUT_RATE]; // [R12]
            if (mode_w == adcr_pkg::MODE_SYNC) begin
                output_clock_select <=
                    regs_q[adcr_pkg::SLOT_OUTPUT][adcr_pkg::LSB_OUT_CLK +: 2]; // [R11]
            end else begin
                output_clock_select <= adcr_pkg::CLK_ECHO; // [R11]
            end
            // The unsupported code is flagged, not corrected.
            output_mode_bad <= mode_w == adcr_pkg::MODE_BAD; // [R16]
        end
    end

    // Lane enables from the lane count field.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_lane_en <= adcr_pkg::LANE_EN_ONE;
        end else begin
            unique case (regs_q[adcr_pkg::SLOT_OUTPUT][adcr_pkg::LSB_OUT_LANES +: 2])
                adcr_pkg::LANES_TWO: output_lane_en <= adcr_pkg::LANE_EN_TWO; // [R13]
                adcr_pkg::LANES_FOUR: output_lane_en <= adcr_pkg::LANE_EN_FOUR; // [R13]
                default: output_lane_en <= adcr_pkg::LANE_EN_ONE; // [R13]
            endcase
        end
    end

    // Data word, pattern, calibration and margin settings for the core.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            output_word_config <= 4'h0;
            pattern_word <= 20'h0_0000;
            offset_ref_select <= 3'h0;
            reference_margin <= 8'h00;
        end else begin
            output_word_config <= regs_q[adcr_pkg::SLOT_WORD][3:0];
            pattern_word <= {regs_q[adcr_pkg::SLOT_PAT_HI][3:0],
                regs_q[adcr_pkg::SLOT_PAT_MID], regs_q[adcr_pkg::SLOT_PAT_LO]};
            offset_ref_select <= regs_q[adcr_pkg::SLOT_OFFSET][2:0];
            reference_margin <= regs_q[adcr_pkg::SLOT_MARGIN];
        end
    end

    // Checks of the power sequencing and register decode.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Converter state is frozen between chip-select rises.
    a_conv_hold: assert property ( // [R3]
        !cs_rise |=> $stable(conv_power_off))
        else $error("converter power changed without chip-select rise");

    // Converter state takes the bit seen at the rise.
    a_conv_follow: assert property ( // [R2]
        cs_rise |=> conv_power_off == $past(power_d[adcr_pkg::BIT_CONV_OFF]))
        else $error("converter power does not match written bit");

    // Buffer state takes the bit seen at the rise and holds otherwise.
    a_refbuf_follow: assert property ( // [R1]
        cs_rise |=> refbuf_power_off == $past(power_d[adcr_pkg::BIT_REFBUF_OFF]))
        else $error("buffer power does not match written bit");

    a_refbuf_hold: assert property ( // [R6]
        !cs_rise |=> $stable(refbuf_power_off))
        else $error("buffer power changed without chip-select rise");

    // Wake pulses come exactly with the off-to-on change.
    a_conv_wake: assert property ( // [R4]
        conv_wake_start |-> $fell(conv_power_off))
        else $error("converter wake pulse without power-up");

    a_refbuf_wake: assert property ( // [R7]
        $fell(refbuf_power_off) |-> refbuf_wake_start)
        else $error("buffer power-up without wake pulse");

    // Reserved bits of the power, input and output registers read zero.
    a_power_rsvd: assert property ( // [R8]
        reg_rd && reg_addr == adcr_pkg::OFS_POWER
        |=> (reg_rdata & ~adcr_pkg::MASK_POWER) == 8'h00)
        else $error("power reserved bits read nonzero");

    a_input_rsvd: assert property ( // [R10]
        reg_rd && reg_addr == adcr_pkg::OFS_INPUT
        |=> (reg_rdata & ~adcr_pkg::MASK_INPUT) == 8'h00)
        else $error("input reserved bits read nonzero");

    a_output_rsvd: assert property ( // [R18]
        reg_rd && reg_addr == adcr_pkg::OFS_OUTPUT |=> !reg_rdata[5])
        else $error("output reserved bit reads nonzero");

    // Unmapped reads return zero one cycle later.
    a_unmapped_zero: assert property ( // [R22]
        reg_rd && rd_slot == adcr_pkg::SLOT_NONE |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("unmapped read returned data");

    // An input mode write reaches the polarity outputs two cycles later.
    a_input_mode: assert property ( // [R9]
        reg_wr && reg_addr == adcr_pkg::OFS_INPUT
        |=> ##1 {in_cpol, in_cpha} == $past(reg_wdata[1:0], 2))
        else $error("input mode not applied");

    // Legacy output follows input framing.
    a_out_follow: assert property ( // [R14]
        !out_source_sync |-> out_cpol == in_cpol && out_cpha == in_cpha)
        else $error("output framing differs from input");

    a_early_mode: assert property ( // [R15]
        out_early_launch |-> !out_source_sync && !out_ddr)
        else $error("early launch outside mode 01");

    a_clock_gate: assert property ( // [R11]
        !out_source_sync |-> output_clock_select == adcr_pkg::CLK_ECHO)
        else $error("clock select active outside mode 11");

    a_ddr_gate: assert property ( // [R12]
        out_ddr |-> out_source_sync)
        else $error("double rate outside mode 11");

    a_sync_mode: assert property ( // [R17]
        out_source_sync == ($past(mode_w) == adcr_pkg::MODE_SYNC))
        else $error("source-synchronous flag wrong");

    a_lane_set: assert property ( // [R13]
        output_lane_en == adcr_pkg::LANE_EN_ONE || output_lane_en == adcr_pkg::LANE_EN_TWO
        || output_lane_en == adcr_pkg::LANE_EN_FOUR)
        else $error("illegal lane enable set");

    a_reset_vals: assert property ( // [R20]
        $rose(rst_b) |-> regs_q[adcr_pkg::SLOT_POWER] == 8'h00
        && regs_q[adcr_pkg::SLOT_OUTPUT] == 8'h00)
        else $error("reset values wrong");

    c_conv_down: cover property (cs_rise ##1 $rose(conv_power_off));
    c_conv_wake: cover property (conv_wake_start);
    c_quad_sync: cover property (out_source_sync && output_lane_en == adcr_pkg::LANE_EN_FOUR);
    c_unmapped: cover property (reg_rd && rd_slot == adcr_pkg::SLOT_NONE);

endmodule : adcr_regs

/* File: test/adcr_host.sv */
`timescale 1ns/1ps
// Host side of the register port: it frames chip select and issues strobes.
module adcr_host #(
    parameter int WAKE_CYC = 8
) (
    input wire logic clk,
    output logic cs_pin_b,
    output logic reg_wr,
    output logic reg_rd,
    output logic [11:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // The port starts idle with chip select released.
    initial begin
        cs_pin_b = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'hfff;
        reg_wdata = 8'h00;
    end

    // Callers never set power bit 0, input bits 7-2, output bit 5 or output mode 10.
    // Only one device sits on this port, so no chained set-up is needed.
    // Released lines show the inverse of their last value, not a held copy.
    task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : write_reg

    // A read is given up if no answer appears within four cycles.
    task automatic read_reg(input logic [11:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end else begin
                @(posedge clk);
            end
        end
    endtask : read_reg

    // Chip select stays low at least three cycles before any write in the frame.
    task automatic cs_low;
        @(posedge clk);
        cs_pin_b <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : cs_low

    // After the rise the host waits out the wake time before the next frame.
    task automatic cs_high;
        @(posedge clk);
        cs_pin_b <= 1'b1;
        repeat (WAKE_CYC) @(posedge clk);
    endtask : cs_high
endmodule : adcr_host

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_pin_b, reg_wr, reg_rd, reg_rvalid, output_mode_bad;
    logic [11:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd, reference_margin;
    logic conv_power_off, refbuf_power_off, conv_wake_start, refbuf_wake_start;
    logic in_cpol, in_cpha, out_cpol, out_cpha, out_early_launch, out_source_sync, out_ddr;
    logic [1:0] output_clock_select, kk, mm;
    logic [3:0] output_lane_en, output_word_config;
    logic [19:0] pattern_word;
    logic [2:0] offset_ref_select;
    int err_count = 0;
    int cmp_count = 0;
    int conv_wakes = 0;
    int ref_wakes = 0;
    localparam logic [11:0] T_ADDR [10] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
        12'h015, 12'h016, 12'h020, 12'h030, 12'h018};
    localparam logic [7:0] T_WR [10] = '{8'hfe, 8'h03, 8'hdf, 8'hff, 8'ha5, 8'h3c, 8'hff,
        8'hff, 8'h5a, 8'hff};
    localparam logic [7:0] T_EXP [10] = '{8'h06, 8'h03, 8'hdf, 8'h0f, 8'ha5, 8'h3c, 8'h0f,
        8'h07, 8'h5a, 8'h00};
    localparam logic [1:0] MLIST [3] = '{adcr_pkg::MODE_SPI, adcr_pkg::MODE_EARLY,
        adcr_pkg::MODE_SYNC};

    // Free-running 25 MHz clock.
    always #20 clk = ~clk;

    // Wake pulses are counted so that a missing or doubled pulse shows.
    always @(posedge clk) begin
        if (conv_wake_start === 1'b1) conv_wakes++;
        if (refbuf_wake_start === 1'b1) ref_wakes++;
    end

    adcr_regs DUT (.clk(clk), .rst_b(rst_b), .cs_pin_b(cs_pin_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .conv_power_off(conv_power_off),
        .refbuf_power_off(refbuf_power_off), .conv_wake_start(conv_wake_start),
        .refbuf_wake_start(refbuf_wake_start), .in_cpol(in_cpol), .in_cpha(in_cpha),
        .out_cpol(out_cpol), .out_cpha(out_cpha), .out_early_launch(out_early_launch),
        .out_source_sync(out_source_sync), .out_ddr(out_ddr),
        .output_clock_select(output_clock_select), .output_lane_en(output_lane_en),
        .output_mode_bad(output_mode_bad), .output_word_config(output_word_config),
        .pattern_word(pattern_word), .offset_ref_select(offset_ref_select),
        .reference_margin(reference_margin));

    adcr_host #(.WAKE_CYC(8)) host (.clk(clk), .cs_pin_b(cs_pin_b), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // Compares one register read.
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    // Compares one single-bit output.
    task automatic chk_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s is %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    // Compares one multi-bit output.
    task automatic chk_vec(input logic [19:0] got, input logic [19:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t %s is %h expected %h", $time, what, got, exp);
        end
    endtask : chk_vec

    // Reads a register and compares it; a missing answer ends the run.
    task automatic do_read(input logic [11:0] a, input logic [7:0] exp);
        logic ok;
        host.read_reg(a, rd, ok);
        if (!ok) begin
            err_count++;
            $display("BAD %0t no read answer", $time);
            print_verdict();
        end else begin
            chk_reg(rd, exp);
        end
    endtask : do_read

    // Lets decoded outputs catch up with the last write.
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Main sequence: reset, map, field decoding, then power frames.
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk_vec(20'(output_lane_en), 20'(adcr_pkg::LANE_EN_ONE), "lanes");
        chk_bit(conv_power_off, 1'b0, "conv off");
        chk_bit(refbuf_power_off, 1'b0, "refbuf off");
        chk_bit(out_source_sync, 1'b0, "sync");
        for (int i = 0; i < 10; i++) do_read(T_ADDR[i], 8'h00);
        for (int i = 0; i < 10; i++) host.write_reg(T_ADDR[i], T_WR[i]);
        for (int i = 0; i < 10; i++) do_read(T_ADDR[i], T_EXP[i]);
        do_read(12'h005, 8'h00);
        settle();
        chk_vec(pattern_word, 20'hf_3ca5, "pattern");
        chk_vec(20'(output_word_config), 20'h0_000f, "word");
        chk_vec(20'(offset_ref_select), 20'h0_0007, "offset");
        chk_vec(20'(reference_margin), 20'h0_005a, "margin");
        chk_bit(conv_power_off, 1'b0, "conv off early");
        chk_bit(refbuf_power_off, 1'b0, "refbuf off early");
        // Every input mode under each legal output mode, with lane and clock codes.
        for (int j = 0; j < 3; j++) begin
            for (int k = 0; k < 4; k++) begin
                kk = 2'(k);
                mm = MLIST[j];
                host.write_reg(adcr_pkg::OFS_INPUT, {6'h00, kk});
                host.write_reg(adcr_pkg::OFS_OUTPUT, {kk, 1'b0, 1'b1, kk, mm});
                settle();
                chk_bit(in_cpol, kk[1], "in cpol");
                chk_bit(in_cpha, kk[0], "in cpha");
                if (mm != adcr_pkg::MODE_SYNC) begin
                    chk_bit(out_cpol, kk[1], "out cpol");
                    chk_bit(out_cpha, kk[0], "out cpha");
                end
                chk_bit(out_early_launch, mm == adcr_pkg::MODE_EARLY, "early");
                chk_bit(out_source_sync, mm == adcr_pkg::MODE_SYNC, "sync");
                chk_bit(out_ddr, mm == adcr_pkg::MODE_SYNC, "ddr");
                chk_bit(output_mode_bad, 1'b0, "mode bad");
                chk_vec(20'(output_clock_select),
                    (mm == adcr_pkg::MODE_SYNC) ? 20'(kk) : 20'h0_0000, "clk sel");
                chk_vec(20'(output_lane_en), 20'(kk[1] ? (kk[0] ? adcr_pkg::LANE_EN_FOUR :
                    adcr_pkg::LANE_EN_TWO) : adcr_pkg::LANE_EN_ONE), "lanes");
            end
        end
        // Converter down: nothing changes until chip select rises.
        host.cs_low();
        host.write_reg(adcr_pkg::OFS_POWER, 8'h02);
        settle();
        chk_bit(conv_power_off, 1'b0, "conv before rise");
        host.cs_high();
        chk_bit(conv_power_off, 1'b1, "conv off");
        chk_bit(refbuf_power_off, 1'b0, "refbuf on");
        chk_vec(20'(conv_wakes + ref_wakes), 20'h0_0000, "wakes");
        // Converter back up and buffer down in the same frame.
        host.cs_low();
        host.write_reg(adcr_pkg::OFS_POWER, 8'h04);
        settle();
        chk_bit(refbuf_power_off, 1'b0, "refbuf before rise");
        host.cs_high();
        chk_bit(conv_power_off, 1'b0, "conv on");
        chk_bit(refbuf_power_off, 1'b1, "refbuf off");
        chk_vec(20'(conv_wakes), 20'h0_0001, "conv wakes");
        // Buffer back up.
        host.cs_low();
        host.write_reg(adcr_pkg::OFS_POWER, 8'h00);
        host.cs_high();
        chk_bit(refbuf_power_off, 1'b0, "refbuf on");
        chk_vec(20'(ref_wakes), 20'h0_0001, "refbuf wakes");
        do_read(adcr_pkg::OFS_POWER, 8'h00);
        print_verdict();
    end
endmodule : tb_top
